// *** src/cwss_top.sv ***
// complementary waveform generator: shutdown, steering, dead-band, blanking, phase delay
// assumes an AXI4-Lite master on aclk; event and shutdown sources arrive asynchronously
`timescale 1ns/1ps
`include "cwss_defs.svh"

module cwss_top
  import cwss_pkg::*;
#(
  parameter int CHAIN_ELEM_CYC = `CWSS_CHAIN_ELEM_CYC
) (
  // clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // asynchronous event and shutdown sources
  input wire logic rise_event_in,
  input wire logic fall_event_in,
  input wire cwss_sd_src_t sd_src_in,
  // waveform outputs, index 0..3 is a..d
  output logic [3:0] wave_out,
  output logic [3:0] wave_oe
);

  // register storage
  logic [7:0] asd1_q, str_q, con1_q, asd0_q;
  logic [5:0] dbr_q, dbf_q, blkr_q, blkf_q, phr_q, phf_q;
  cwss_cfg_t cfg;

  // synchronisers: stage one feeds stage two only
  logic [5:0] sync1_q, sync2_q;
  logic rise_prev_q, fall_prev_q;
  logic [5:0] async_in;
  assign async_in = {rise_event_in, fall_event_in, sd_src_in};

  always_ff @(posedge aclk) begin
    if (clk_en) begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
      rise_prev_q <= sync2_q[5];
      fall_prev_q <= sync2_q[4];
    end
  end

  cwss_sd_src_t src_s;
  assign src_s = cwss_sd_src_t'(sync2_q[3:0]);

  assign cfg.sd_en = asd1_q[3:0];
  assign cfg.static_lvl = str_q[7:4];
  assign cfg.steer = str_q[3:0];
  assign cfg.polarity = con1_q[3:0];
  assign cfg.rise_db_chain = con1_q[`CWSS_CON1_RDBS];
  assign cfg.fall_db_chain = con1_q[`CWSS_CON1_FDBS];
  assign cfg.auto_restart = asd0_q[`CWSS_ASD0_ARSEN];
  assign cfg.ovr_bd = asd0_q[`CWSS_ASD0_BD_LO +: 2];
  assign cfg.ovr_ac = asd0_q[`CWSS_ASD0_AC_LO +: 2];

  // shutdown request
  wire sd_l2 = cfg.sd_en[3] & ~src_s.logic_cell_two;
  wire sd_c2 = cfg.sd_en[2] & ~src_s.cmp2;
  wire sd_c1 = cfg.sd_en[1] & ~src_s.cmp1;
  wire sd_pin = cfg.sd_en[0] & ~src_s.remap_pin;
  wire sd_req = sd_l2 | sd_c2 | sd_c1 | sd_pin;

  // axi4-lite slave
  logic aw_rdy_q, ar_rdy_q, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  wire wr_go = aw_rdy_q & s_axi_awvalid & s_axi_wvalid;
  wire rd_go = ar_rdy_q & s_axi_arvalid;
  wire wr_lane0 = wr_go & s_axi_wstrb[0];
  wire [7:0] wbyte = s_axi_wdata[7:0];
  wire wr_asd1 = wr_lane0 & (s_axi_awaddr == `CWSS_OFF_ASD1);
  wire wr_str = wr_lane0 & (s_axi_awaddr == `CWSS_OFF_STR);
  wire wr_dbr = wr_lane0 & (s_axi_awaddr == `CWSS_OFF_DBR);
  wire wr_dbf = wr_lane0 & (s_axi_awaddr == `CWSS_OFF_DBF);
  wire wr_blkr = wr_lane0 & (s_axi_awaddr == `CWSS_OFF_BLKR);
  wire wr_blkf = wr_lane0 & (s_axi_awaddr == `CWSS_OFF_BLKF);
  wire wr_phr = wr_lane0 & (s_axi_awaddr == `CWSS_OFF_PHR);
  wire wr_phf = wr_lane0 & (s_axi_awaddr == `CWSS_OFF_PHF);
  wire wr_asd0 = wr_lane0 & (s_axi_awaddr == `CWSS_OFF_ASD0);
  wire wr_con1 = wr_lane0 & (s_axi_awaddr == `CWSS_OFF_CON1);
  wire wr_hit = (s_axi_awaddr[7:6] == 2'b00) & (s_axi_awaddr[1:0] == 2'b00) &
                (s_axi_awaddr[5:2] <= 4'h9);
  wire rd_hit = (s_axi_araddr[7:6] == 2'b00) & (s_axi_araddr[1:0] == 2'b00) &
                (s_axi_araddr[5:2] <= 4'h9);

  cwss_sd_state_t sd_state_q;
  wire sd_status = (sd_state_q == CWSS_SHUT);

  logic [7:0] rbyte;
  always_comb begin
    case (s_axi_araddr)
      `CWSS_OFF_ASD1: rbyte = asd1_q & `CWSS_ASD1_MASK;
      `CWSS_OFF_STR: rbyte = str_q;
      `CWSS_OFF_DBR: rbyte = {2'b00, dbr_q};
      `CWSS_OFF_DBF: rbyte = {2'b00, dbf_q};
      `CWSS_OFF_BLKR: rbyte = {2'b00, blkr_q};
      `CWSS_OFF_BLKF: rbyte = {2'b00, blkf_q};
      `CWSS_OFF_PHR: rbyte = {2'b00, phr_q};
      `CWSS_OFF_PHF: rbyte = {2'b00, phf_q};
      `CWSS_OFF_ASD0: rbyte = {sd_status, asd0_q[6:2], 2'b00};
      `CWSS_OFF_CON1: rbyte = con1_q;
      default: rbyte = `CWSS_RST_BYTE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_rdy_q <= 1'b0;
      ar_rdy_q <= 1'b0;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= `CWSS_RESP_OKAY;
      rresp_q <= `CWSS_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      // ready is offered one cycle after both channels show valid
      aw_rdy_q <= s_axi_awvalid & s_axi_wvalid & ~aw_rdy_q & ~bvalid_q;
      ar_rdy_q <= s_axi_arvalid & ~ar_rdy_q & ~rvalid_q;
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? `CWSS_RESP_OKAY : `CWSS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_go) begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_hit ? `CWSS_RESP_OKAY : `CWSS_RESP_SLVERR;
        rdata_q <= {24'h00_0000, rbyte};
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // control registers clear on every reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      asd1_q <= `CWSS_RST_BYTE;
      str_q <= `CWSS_RST_BYTE;
      asd0_q <= `CWSS_RST_BYTE;
      con1_q <= `CWSS_RST_BYTE;
    end else if (clk_en) begin
      if (wr_asd1) asd1_q <= wbyte & `CWSS_ASD1_MASK;
      if (wr_str) str_q <= wbyte;
      if (wr_asd0) asd0_q <= wbyte & `CWSS_ASD0_MASK;
      if (wr_con1) con1_q <= wbyte & `CWSS_CON1_MASK;
    end
  end

  // count registers have no reset: unknown at power-up, kept across resets
  always_ff @(posedge aclk) begin
    if (clk_en) begin
      if (wr_dbr) dbr_q <= wbyte[5:0];
      if (wr_dbf) dbf_q <= wbyte[5:0];
      if (wr_blkr) blkr_q <= wbyte[5:0];
      if (wr_blkf) blkf_q <= wbyte[5:0];
      if (wr_phr) phr_q <= wbyte[5:0];
      if (wr_phf) phf_q <= wbyte[5:0];
    end
  end

  // event edges, blanking and phase delay
  logic [5:0] blk_r_cnt_q, blk_f_cnt_q, ph_r_cnt_q, ph_f_cnt_q;
  logic ph_r_pend_q, ph_f_pend_q;
  wire rise_edge = sync2_q[5] & ~rise_prev_q;
  wire fall_edge = sync2_q[4] & ~fall_prev_q;
  wire rise_take = rise_edge & (blk_f_cnt_q == 6'd0);
  wire fall_take = fall_edge & (blk_r_cnt_q == 6'd0);
  wire rise_fire = ph_r_pend_q & (ph_r_cnt_q == 6'd0);
  wire fall_fire = ph_f_pend_q & (ph_f_cnt_q == 6'd0) & ~rise_fire;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blk_r_cnt_q <= 6'd0;
      blk_f_cnt_q <= 6'd0;
      ph_r_cnt_q <= 6'd0;
      ph_f_cnt_q <= 6'd0;
      ph_r_pend_q <= 1'b0;
      ph_f_pend_q <= 1'b0;
    end else if (clk_en) begin
      if (rise_take) begin
        ph_r_pend_q <= 1'b1;
        ph_r_cnt_q <= phr_q;
        blk_r_cnt_q <= blkr_q;
      end else if (rise_fire) begin
        ph_r_pend_q <= 1'b0;
      end else if (ph_r_pend_q) begin
        ph_r_cnt_q <= ph_r_cnt_q - 6'd1;
      end
      if (!rise_take && blk_r_cnt_q != 6'd0) blk_r_cnt_q <= blk_r_cnt_q - 6'd1;
      if (fall_take) begin
        ph_f_pend_q <= 1'b1;
        ph_f_cnt_q <= phf_q;
        blk_f_cnt_q <= blkf_q;
      end else if (fall_fire) begin
        ph_f_pend_q <= 1'b0;
      end else if (ph_f_pend_q && ph_f_cnt_q != 6'd0) begin
        ph_f_cnt_q <= ph_f_cnt_q - 6'd1;
      end
      if (!fall_take && blk_f_cnt_q != 6'd0) blk_f_cnt_q <= blk_f_cnt_q - 6'd1;
    end
  end

  // dead-band: chain mode scales the value by the element length in clocks
  logic [11:0] db_r_cnt_q, db_f_cnt_q;
  logic prim_q, comp_q, prim_pend_q, comp_pend_q;
  wire [11:0] elem = 12'(CHAIN_ELEM_CYC);
  wire [11:0] db_r_load = cfg.rise_db_chain ? 12'({6'd0, dbr_q} * elem)
                                            : {6'd0, dbr_q};
  wire [11:0] db_f_load = cfg.fall_db_chain ? 12'({6'd0, dbf_q} * elem)
                                            : {6'd0, dbf_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prim_q <= 1'b0;
      comp_q <= 1'b0;
      prim_pend_q <= 1'b0;
      comp_pend_q <= 1'b0;
      db_r_cnt_q <= 12'd0;
      db_f_cnt_q <= 12'd0;
    end else if (clk_en) begin
      if (rise_fire) begin
        comp_q <= 1'b0;
        comp_pend_q <= 1'b0;
        db_r_cnt_q <= db_r_load;
        // a zero dead-band lets the primary rise at the edge the complement falls
        if (db_r_load == 12'd0) begin
          prim_q <= 1'b1;
          prim_pend_q <= 1'b0;
        end else begin
          prim_pend_q <= 1'b1;
        end
      end else if (fall_fire) begin
        prim_q <= 1'b0;
        prim_pend_q <= 1'b0;
        db_f_cnt_q <= db_f_load;
        if (db_f_load == 12'd0) begin
          comp_q <= 1'b1;
          comp_pend_q <= 1'b0;
        end else begin
          comp_pend_q <= 1'b1;
        end
      end else begin
        // the last period of the delay is spent in the edge that moves the output
        if (prim_pend_q) begin
          if (db_r_cnt_q <= 12'd1) begin
            prim_q <= 1'b1;
            prim_pend_q <= 1'b0;
          end else begin
            db_r_cnt_q <= db_r_cnt_q - 12'd1;
          end
        end
        if (comp_pend_q) begin
          if (db_f_cnt_q <= 12'd1) begin
            comp_q <= 1'b1;
            comp_pend_q <= 1'b0;
          end else begin
            db_f_cnt_q <= db_f_cnt_q - 12'd1;
          end
        end
      end
    end
  end

  // shutdown state: a new request always wins over a pending exit
  cwss_sd_state_t sd_state_d;
  wire sw_clear = wr_asd0 & ~wbyte[`CWSS_ASD0_STAT];
  wire sw_set = wr_asd0 & wbyte[`CWSS_ASD0_STAT];
  always_comb begin
    sd_state_d = sd_state_q;
    case (sd_state_q)
      CWSS_RUN: if (sd_req || sw_set) sd_state_d = CWSS_SHUT;
      CWSS_SHUT: begin
        if (!sd_req && (cfg.auto_restart || sw_clear)) sd_state_d = CWSS_WAIT_RISE;
      end
      CWSS_WAIT_RISE: begin
        if (sd_req || sw_set) sd_state_d = CWSS_SHUT;
        else if (rise_fire) sd_state_d = CWSS_RUN;
      end
      default: sd_state_d = CWSS_SHUT;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) sd_state_q <= CWSS_RUN;
    else if (clk_en) sd_state_q <= sd_state_d;
  end

  // outputs: a,c carry primary; b,d carry complement
  wire [3:0] wave_raw = {comp_q, prim_q, comp_q, prim_q};
  wire [3:0] steered;
  wire [3:0] ovr_lvl;
  wire [3:0] ovr_oe;
  wire overriding = (sd_state_q != CWSS_RUN);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_out
      wire [1:0] code = (gi % 2 == 1) ? cfg.ovr_bd : cfg.ovr_ac;
      assign steered[gi] = cfg.steer[gi] ? (wave_raw[gi] ^ cfg.polarity[gi])
                                         : cfg.static_lvl[gi];
      assign ovr_lvl[gi] = (code == `CWSS_OVR_HIGH) ? 1'b1 :
                           (code == `CWSS_OVR_LOW) ? 1'b0 :
                           (code == `CWSS_OVR_TRI) ? 1'b0 : cfg.polarity[gi];
      assign ovr_oe[gi] = (code != `CWSS_OVR_TRI);
    end
  endgenerate

  logic [3:0] wave_q, oe_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_q <= 4'h0;
      oe_q <= 4'hF;
    end else if (clk_en) begin
      wave_q <= overriding ? ovr_lvl : steered;
      oe_q <= overriding ? ovr_oe : 4'hF;
    end
  end

  assign wave_out = wave_q;
  assign wave_oe = oe_q;
  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready = aw_rdy_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

endmodule

// *** src/cwss_defs.svh ***
// register offsets, field positions, reset values and timing counts of the waveform steer block
// assumes an 8-bit AXI4-Lite byte address, one aligned 32-bit word per register
`ifndef CWSS_DEFS_SVH
`define CWSS_DEFS_SVH

`define CWSS_OFF_ASD1 8'h00
`define CWSS_OFF_STR 8'h04
`define CWSS_OFF_DBR 8'h08
`define CWSS_OFF_DBF 8'h0C
`define CWSS_OFF_BLKR 8'h10
`define CWSS_OFF_BLKF 8'h14
`define CWSS_OFF_PHR 8'h18
`define CWSS_OFF_PHF 8'h1C
`define CWSS_OFF_ASD0 8'h20
`define CWSS_OFF_CON1 8'h24

`define CWSS_ASD1_MASK 8'h0F
`define CWSS_ASD0_MASK 8'hFC
`define CWSS_CON1_MASK 8'hCF
`define CWSS_CNT_MASK 8'h3F
`define CWSS_RST_BYTE 8'h00

`define CWSS_ASD0_STAT 7
`define CWSS_ASD0_ARSEN 6
`define CWSS_ASD0_BD_LO 4
`define CWSS_ASD0_AC_LO 2
`define CWSS_CON1_RDBS 7
`define CWSS_CON1_FDBS 6

`define CWSS_OVR_HIGH 2'b11
`define CWSS_OVR_LOW 2'b10
`define CWSS_OVR_TRI 2'b01

`define CWSS_CLK_PERIOD_NS 8
`define CWSS_CHAIN_ELEM_NS 8
`define CWSS_CHAIN_ELEM_CYC \
  ((`CWSS_CHAIN_ELEM_NS + `CWSS_CLK_PERIOD_NS - 1) / `CWSS_CLK_PERIOD_NS)

`define CWSS_RESP_OKAY 2'b00
`define CWSS_RESP_SLVERR 2'b10

`endif

// *** src/cwss_pkg.sv ***
// types shared by the waveform steer block
// assumes nothing beyond the defs header
package cwss_pkg;

  typedef enum logic [1:0] {
    CWSS_RUN = 2'b00,
    CWSS_SHUT = 2'b01,
    CWSS_WAIT_RISE = 2'b10
  } cwss_sd_state_t;

  typedef struct packed {
    logic [3:0] sd_en;
    logic [3:0] static_lvl;
    logic [3:0] steer;
    logic [3:0] polarity;
    logic rise_db_chain;
    logic fall_db_chain;
    logic auto_restart;
    logic [1:0] ovr_bd;
    logic [1:0] ovr_ac;
  } cwss_cfg_t;

  typedef struct packed {
    logic cmp1;
    logic cmp2;
    logic logic_cell_two;
    logic remap_pin;
  } cwss_sd_src_t;

endpackage

// *** testbench/cwss_switch_model.sv ***
// model of the power switch drivers on the four waveform outputs
// assumes a pull-down at each gate input, so a released output reads low
`timescale 1ns/1ps
module cwss_switch_model (
  // from the block
  input wire logic [3:0] wave_out,
  input wire logic [3:0] wave_oe,
  // level seen at the switch gates
  output logic [3:0] gate_lvl
);
  assign gate_lvl = wave_out & wave_oe;
endmodule

// *** testbench/cwss_top_properties.sv ***
// concurrent checks on the ports of the waveform steer block
// assumes one clock aclk and the synchronous active-low aresetn
`timescale 1ns/1ps
module cwss_chk (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // outputs
  input wire logic [3:0] wave_out,
  input wire logic [3:0] wave_oe
);
  logic [7:0] rd_a_q;
  logic [7:0] str_q;
  logic [3:0] asd1_q;
  logic touched_q;
  logic [1:0] age_q;
  wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wstrb[0];
  // static check only while no shutdown can be pending, since status is software-settable
  wire quiet = asd1_q == 4'h0 && !touched_q && age_q == 2'h3;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_a_q <= 8'h00;
      str_q <= 8'h00;
      asd1_q <= 4'h0;
      touched_q <= 1'b0;
      age_q <= 2'h3;
    end else begin
      if (s_axi_arvalid && s_axi_arready) rd_a_q <= s_axi_araddr;
      if (wr_go && s_axi_awaddr == 8'h00) asd1_q <= s_axi_wdata[3:0];
      if (wr_go && s_axi_awaddr == 8'h20) touched_q <= 1'b1;
      if (wr_go && s_axi_awaddr == 8'h04) begin
        str_q <= s_axi_wdata[7:0];
        age_q <= 2'h0;
      end else if (age_q != 2'h3) begin
        age_q <= age_q + 2'h1;
      end
    end
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arready && s_axi_arvalid;
  endsequence
  a_write_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write response missing");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read response missing");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rvalid_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  a_ready_pair: assert property (s_axi_awready |-> s_axi_wready && !s_axi_bvalid)
    else $error("write readies apart");
  a_en_upper: assert property (
    s_axi_rvalid && rd_a_q == 8'h00 |-> s_axi_rdata[31:4] == 28'h000_0000)
    else $error("source enable upper bits set");
  a_count_upper: assert property (
    s_axi_rvalid && rd_a_q inside {[8'h08:8'h1C]} |-> s_axi_rdata[31:6] == 26'h000_0000)
    else $error("count upper bits set");
  a_static_drive: assert property (
    quiet |-> ((wave_out ^ str_q[7:4]) & ~str_q[3:0]) == 4'h0 && wave_oe == 4'hF)
    else $error("static level not driven");
endmodule
bind cwss_top cwss_chk cwss_chk_i (.*);

// *** testbench/cwss_top_tb.sv ***
// self-checking bench of the waveform steer block
// assumes the switch model as load and bus tasks as the only register access
`timescale 1ns/1ps
`include "cwss_defs.svh"
module cwss_top_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic rise = 1'b0, fall = 1'b0;
  logic [3:0] sd = 4'hF;
  wire awr, wrr, bv, arr, rv;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] wo, oe, gl;
  int bad_count = 0;
  int n_tests = 0;
  int sbit [4] = '{0, 3, 2, 1};
  logic [7:0] dly [8] = '{8'h00, 8'h00, 8'h03, 8'h05, 8'h00, 8'h00, 8'h02, 8'h02};
  logic [31:0] d;
  logic [1:0] r;
  logic [1:0] wb;
  int ta, tb, t0, t1;
  initial forever #4 aclk = ~aclk;
  // chain element stretched to two cycles so chain and clock modes differ
  cwss_top #(.CHAIN_ELEM_CYC(2)) cwss_top_i (
    .aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrr),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .rise_event_in(rise), .fall_event_in(fall), .sd_src_in(sd),
    .wave_out(wo), .wave_oe(oe)
  );
  cwss_switch_model cwss_switch_model_i (.wave_out(wo), .wave_oe(oe), .gate_lvl(gl));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    wt(4);
    aresetn <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (awr !== 1'b1);
    awv <= 1'b0;
    wv <= 1'b0;
    do begin
      @(posedge aclk);
    end while (bv !== 1'b1);
    wb = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
    end while (arr !== 1'b1);
    arv <= 1'b0;
    do begin
      @(posedge aclk);
    end while (rv !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  // one event pulse, then the cycle at which output a and output b first change
  task automatic ev(input logic up, output int ea, output int eb);
    logic [3:0] w0;
    ea = -1;
    eb = -1;
    @(posedge aclk);
    w0 = wo;
    if (up) rise <= 1'b1;
    else fall <= 1'b1;
    for (int n = 1; n < 80; n++) begin
      @(posedge aclk);
      if (n == 3) begin
        rise <= 1'b0;
        fall <= 1'b0;
      end
      if (ea < 0 && wo[0] !== w0[0]) ea = n;
      if (eb < 0 && wo[1] !== w0[1]) eb = n;
    end
  endtask
  initial begin
    rst();
    rd(8'h00, d, r);
    chk("enable reset", d, 32'h0000_0000);
    chk("read okay", r, `CWSS_RESP_OKAY);
    rd(8'h40, d, r);
    chk("unmapped resp", r, `CWSS_RESP_SLVERR);
    chk("outputs reset", {wo, oe}, 32'h0000_000F);
    wr(8'h40, 8'h00);
    chk("write unmapped", wb, `CWSS_RESP_SLVERR);
    wr(8'h04, 8'hA0);
    chk("write okay", wb, `CWSS_RESP_OKAY);
    wt(3);
    chk("static high", wo, 4'hA);
    wr(8'h04, 8'h50);
    wt(3);
    chk("static swap", wo, 4'h5);
    wr(8'h00, 8'hFF);
    rd(8'h00, d, r);
    chk("enable mask", d, 32'h0000_000F);
    for (int i = 2; i < 8; i++) wr(8'(i * 4), 8'hFF);
    rst();
    for (int i = 2; i < 8; i++) begin
      rd(8'(i * 4), d, r);
      chk("count kept", d, 32'h0000_003F);
    end
    rd(8'h04, d, r);
    chk("steer cleared", d, 32'h0000_0000);
    $display("registers done");
    for (int c = 0; c < 4; c++) begin
      wr(8'h20, 8'(8'h80 | c * 20));
      wt(4);
      chk("override gate", gl, c == 3 ? 4'hF : 4'h0);
      chk("override enable", oe, c == 1 ? 4'h0 : 4'hF);
    end
    rd(8'h20, d, r);
    chk("status shut", d[7], 1'b1);
    $display("override done");
    wr(8'h20, 8'h40);
    for (int i = 0; i < 4; i++) begin
      sd <= 4'hF & ~(4'h1 << sbit[i]);
      wt(6);
      rd(8'h20, d, r);
      chk("source masked", d[7], 1'b0);
      wr(8'h00, 8'(1 << i));
      wt(2);
      rd(8'h20, d, r);
      chk("source shut", d[7], 1'b1);
      sd <= 4'hF;
      wt(6);
      rd(8'h20, d, r);
      chk("auto restart", d[7], 1'b0);
      wr(8'h00, 8'h00);
    end
    wr(8'h20, 8'h00);
    sd <= 4'hE;
    wr(8'h00, 8'h01);
    sd <= 4'hF;
    wt(6);
    rd(8'h20, d, r);
    chk("no restart", d[7], 1'b1);
    wr(8'h00, 8'h00);
    $display("shutdown done");
    wr(8'h20, 8'h00);
    wr(8'h04, 8'h0F);
    for (int i = 2; i < 8; i++) wr(8'(i * 4), dly[i]);
    ev(1'b1, ta, tb);
    ev(1'b0, ta, tb);
    chk("fall dead", tb - ta, 5);
    ev(1'b1, ta, t0);
    chk("rise dead", ta - t0, 3);
    ev(1'b0, ta, tb);
    wr(8'h18, 8'h07);
    ev(1'b1, ta, t1);
    chk("rise phase", t1 - t0, 5);
    wr(8'h24, 8'hC0);
    ev(1'b0, t0, tb);
    chk("fall chain", tb - t0, 10);
    ev(1'b1, ta, tb);
    chk("rise chain", ta - tb, 6);
    wr(8'h1C, 8'h06);
    ev(1'b0, t1, tb);
    chk("fall phase", t1 - t0, 4);
    wr(8'h10, 8'h3F);
    rise <= 1'b1;
    wt(3);
    rise <= 1'b0;
    wt(12);
    fall <= 1'b1;
    wt(3);
    fall <= 1'b0;
    wt(30);
    chk("blanked fall", wo[0], 1'b1);
    wr(8'h24, 8'hC1);
    wt(3);
    chk("polarity a", wo[0], 1'b0);
    wr(8'h14, 8'h3F);
    wt(20);
    fall <= 1'b1;
    wt(3);
    fall <= 1'b0;
    wt(12);
    rise <= 1'b1;
    wt(3);
    rise <= 1'b0;
    wt(30);
    chk("blanked rise", wo[1], 1'b1);
    $display("waveform done");
    tally_and_finish();
  end
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule
